// file: gbu_uplink_dev.sv
// burst uplink device: serial receive, burst buffers, gmsk, dac drive
`timescale 1ns/100ps
`include "gbu_params.svh"
module gbu_uplink_dev
	import gbu_pkg::*;
#(
	parameter int SAMPLE_DIV   = `GBU_SAMPLE_DIV,
	parameter int SETTLE_CYC   = `GBU_SETTLE_CYC,
	parameter int CAL_STEP_CYC = `GBU_CAL_STEP_CYC
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	gbu_link_if.dev         lnk,
	input  wire logic       i_cmp_i_high,
	input  wire logic       i_cmp_q_high,
	output logic [9:0]      o_dac_i,
	output logic [9:0]      o_dac_q,
	output logic [5:0]      o_sub_dac_i,
	output logic [5:0]      o_sub_dac_q,
	output logic            o_uplink_power,
	output logic [2:0]      o_out_level,
	output logic [2:0]      o_common_mode
);
	localparam int DW = $clog2(SAMPLE_DIV);
	localparam int SW = $clog2(SETTLE_CYC + 1);
	localparam int CW = $clog2(CAL_STEP_CYC + 1);
	localparam logic [191:0] GAUSS_TAB = {
		6'h26, 6'h26, 6'h26, 6'h25, 6'h25, 6'h23, 6'h22, 6'h20,
		6'h1C, 6'h1A, 6'h18, 6'h16, 6'h14, 6'h12, 6'h10, 6'h0E,
		6'h0C, 6'h0A, 6'h08, 6'h07, 6'h05, 6'h04, 6'h03, 6'h02,
		6'h02, 6'h01, 6'h01, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
	localparam logic [152:0] SINE_TAB = {
		9'h1FF, 9'h1FD, 9'h1F5, 9'h1E9, 9'h1D8, 9'h1C3, 9'h1A9, 9'h18B,
		9'h169, 9'h145, 9'h11C, 9'h0F1, 9'h0C4, 9'h094, 9'h064, 9'h032,
		9'h000};

	if (SAMPLE_DIV < 2 || SETTLE_CYC < 1 || CAL_STEP_CYC < 1) begin : g_bad
		$error("gbu_uplink_dev: timing parameter out of range");
	end

	// gaussian phase pulse over four bit periods, symmetric halves
	function automatic logic [5:0] gauss(input logic [5:0] j);
		logic [4:0] h;
		h = j[5] ? ~j[4:0] : j[4:0];
		gauss = GAUSS_TAB[h*6 +: 6];
	endfunction

	function automatic logic [9:0] sine(input logic [5:0] p);
		logic [4:0] k;
		logic [9:0] m;
		k = p[4] ? 5'h10 - {1'b0, p[3:0]} : {1'b0, p[3:0]};
		m = {1'b0, SINE_TAB[k*9 +: 9]};
		sine = p[5] ? 10'(-m) : m;
	endfunction

	logic [15:0]    rx_sh_q;
	logic [4:0]     rx_cnt_q;
	logic           rx_ctrl_q;
	logic           rx_done;
	logic [15:0]    rx_word;
	logic [15:0]    ctrl_q;
	logic           slot_mode;
	logic [15:0]    mem [0:2*`GBU_BUF_WORDS-1];
	logic [1:0]     full_q;
	logic           play_sel_q;
	logic           cur_buf_q;
	logic           load_sel;
	logic           play_buf;
	logic [3:0]     wr_word_q;
	logic [SW-1:0]  settle_q;
	logic           powered_q;
	logic [DW-1:0]  div_q;
	logic           tick;
	logic           mod_win_q;
	gbu_mod_state_t state_q;
	logic           mod_start;
	logic           mod_end;
	logic [7:0]     tail_q;
	logic [3:0]     samp_q;
	logic [3:0]     rd_word_q;
	logic [3:0]     rd_bit_q;
	logic [3:0]     win_q;
	logic           next_bit;
	logic [11:0]    phase_q;
	logic [11:0]    inc;
	logic           cal_on;
	logic [CW-1:0]  cal_cnt_q;
	logic           cmp_i_m_q;
	logic           cmp_i_s_q;
	logic           cmp_q_m_q;
	logic           cmp_q_s_q;
	logic [5:0]     ofs_i_q;
	logic [5:0]     ofs_q_q;
	logic           load_ready_q;
	logic           busy_q;

	// packet receiver, msb first, sync marks the first bit
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			rx_cnt_q  <= 5'h00;
			rx_sh_q   <= 16'h0000;
			rx_ctrl_q <= 1'b0;
		end else if (lnk.pkt_sync) begin
			rx_cnt_q  <= 5'h0F;
			rx_sh_q   <= {15'h0000, lnk.pkt_data};
			rx_ctrl_q <= lnk.pkt_is_ctrl;
		end else if (rx_cnt_q != 5'h00) begin
			rx_cnt_q <= rx_cnt_q - 5'h01;
			rx_sh_q  <= {rx_sh_q[14:0], lnk.pkt_data};
		end
	end
	assign rx_done = (rx_cnt_q == 5'h01);
	assign rx_word = {rx_sh_q[14:0], lnk.pkt_data};

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn)
			ctrl_q <= `GBU_CTRL_RST;
		else if (rx_done && rx_ctrl_q)
			ctrl_q <= rx_word;
	end
	assign slot_mode = ctrl_q[`GBU_SLOT_BIT];
	assign play_buf  = slot_mode ? play_sel_q : 1'b0;
	assign load_sel  = slot_mode ? (full_q[play_sel_q] ? ~play_sel_q
		: play_sel_q) : 1'b0;

	// burst load: ten words fill a buffer, a full buffer refuses words
	always_ff @(posedge i_core_clk) begin
		if (rx_done && !rx_ctrl_q && !full_q[load_sel])
			mem[load_sel ? 5'(wr_word_q) + 5'h0A : 5'(wr_word_q)] <= rx_word;
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			full_q     <= 2'h0;
			wr_word_q  <= 4'h0;
			play_sel_q <= 1'b0;
		end else begin
			if (mod_end) begin
				full_q[cur_buf_q] <= 1'b0;
				if (slot_mode)
					play_sel_q <= ~cur_buf_q;
			end
			if (rx_done && !rx_ctrl_q && !full_q[load_sel]) begin
				if (wr_word_q == 4'(`GBU_BUF_WORDS - 1)) begin
					wr_word_q        <= 4'h0;
					full_q[load_sel] <= 1'b1;
				end else begin
					wr_word_q <= wr_word_q + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			settle_q  <= '0;
			powered_q <= 1'b0;
		end else if (!lnk.power_win) begin
			settle_q  <= '0;
			powered_q <= 1'b0;
		end else if (settle_q == SW'(SETTLE_CYC)) begin
			powered_q <= 1'b1;
		end else begin
			settle_q <= settle_q + SW'(1);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn)
			div_q <= '0;
		else
			div_q <= tick ? '0 : div_q + DW'(1);
	end
	assign tick = (div_q == DW'(SAMPLE_DIV - 1));

	assign mod_start = (state_q == GBU_M_IDLE) && lnk.mod_win && !mod_win_q
		&& powered_q && full_q[play_buf];
	assign mod_end = (state_q == GBU_M_TAIL) && tick
		&& (tail_q == 8'(`GBU_TAIL_SAMPLES - 1));

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			state_q   <= GBU_M_IDLE;
			mod_win_q <= 1'b0;
			tail_q    <= 8'h00;
			cur_buf_q <= 1'b0;
		end else begin
			mod_win_q <= lnk.mod_win;
			case (state_q)
				GBU_M_IDLE: begin
					if (mod_start) begin
						state_q   <= GBU_M_RUN;
						cur_buf_q <= play_buf;
					end
				end
				GBU_M_RUN: begin
					tail_q <= 8'h00;
					if (!lnk.mod_win)
						state_q <= GBU_M_TAIL;
				end
				GBU_M_TAIL: begin
					if (mod_end)
						state_q <= GBU_M_IDLE;
					else if (tick)
						tail_q <= tail_q + 8'h01;
				end
				default: state_q <= GBU_M_IDLE;
			endcase
		end
	end

	// bits past the burst end read as ones
	assign next_bit = (rd_word_q < 4'(`GBU_BUF_WORDS))
		? mem[cur_buf_q ? 5'(rd_word_q) + 5'h0A : 5'(rd_word_q)][~rd_bit_q]
		: 1'b1;

	always_comb begin
		inc = 12'h000;
		for (int k = 0; k < 4; k++) begin
			if (win_q[k])
				inc = inc + 12'(gauss(6'(k * `GBU_OVERSAMPLE) + 6'(samp_q)));
			else
				inc = inc - 12'(gauss(6'(k * `GBU_OVERSAMPLE) + 6'(samp_q)));
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn || mod_end || state_q == GBU_M_IDLE) begin
			samp_q    <= 4'h0;
			rd_word_q <= 4'h0;
			rd_bit_q  <= 4'h0;
			win_q     <= 4'hF;
			phase_q   <= 12'h000;
		end else if (tick) begin
			phase_q <= phase_q + inc;
			samp_q  <= samp_q + 4'h1;
			if (samp_q == 4'(`GBU_OVERSAMPLE - 1)) begin
				win_q    <= {win_q[2:0], next_bit};
				rd_bit_q <= rd_bit_q + 4'h1;
				if (rd_bit_q == 4'hF && rd_word_q < 4'(`GBU_BUF_WORDS))
					rd_word_q <= rd_word_q + 4'h1;
			end
		end
	end

	assign cal_on = lnk.cal_win && powered_q;

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			o_dac_i <= 10'h1FF;
			o_dac_q <= 10'h000;
		end else if (cal_on) begin
			o_dac_i <= 10'h000;
			o_dac_q <= 10'h000;
		end else if (tick) begin
			o_dac_i <= sine(6'(phase_q[11:6] + 6'h10));
			o_dac_q <= sine(phase_q[11:6]);
		end
	end

	// comparator levels come from the analog side
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			cmp_i_m_q <= 1'b0;
			cmp_i_s_q <= 1'b0;
			cmp_q_m_q <= 1'b0;
			cmp_q_s_q <= 1'b0;
		end else begin
			cmp_i_m_q <= i_cmp_i_high;
			cmp_i_s_q <= cmp_i_m_q;
			cmp_q_m_q <= i_cmp_q_high;
			cmp_q_s_q <= cmp_q_m_q;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			cal_cnt_q <= '0;
			ofs_i_q   <= `GBU_OFS_RST;
			ofs_q_q   <= `GBU_OFS_RST;
		end else if (!cal_on) begin
			cal_cnt_q <= '0;
		end else if (cal_cnt_q != CW'(CAL_STEP_CYC - 1)) begin
			cal_cnt_q <= cal_cnt_q + CW'(1);
		end else begin
			cal_cnt_q <= '0;
			if (cmp_i_s_q && ofs_i_q != 6'h00)
				ofs_i_q <= ofs_i_q - 6'h01;
			else if (!cmp_i_s_q && ofs_i_q != 6'h3F)
				ofs_i_q <= ofs_i_q + 6'h01;
			if (cmp_q_s_q && ofs_q_q != 6'h00)
				ofs_q_q <= ofs_q_q - 6'h01;
			else if (!cmp_q_s_q && ofs_q_q != 6'h3F)
				ofs_q_q <= ofs_q_q + 6'h01;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			load_ready_q <= 1'b0;
			busy_q       <= 1'b0;
		end else begin
			load_ready_q <= !full_q[load_sel];
			busy_q       <= (state_q != GBU_M_IDLE);
		end
	end

	assign o_sub_dac_i    = ofs_i_q;
	assign o_sub_dac_q    = ofs_q_q;
	assign o_uplink_power = powered_q;
	assign o_out_level    = ctrl_q[`GBU_LEVEL_MSB:`GBU_LEVEL_LSB];
	assign o_common_mode  = ctrl_q[`GBU_CM_MSB:`GBU_CM_LSB];
	assign lnk.load_ready = load_ready_q;
	assign lnk.powered    = powered_q;
	assign lnk.modulating = busy_q;
endmodule // gbu_uplink_dev

// file: gbu_params.svh
// timing, layout and reset constants for the burst uplink modulator
`ifndef GBU_PARAMS_SVH
`define GBU_PARAMS_SVH
`define GBU_CTRL_RST      16'h0000
`define GBU_CM_LSB        0
`define GBU_CM_MSB        2
`define GBU_SLOT_BIT      5
`define GBU_LEVEL_LSB     6
`define GBU_LEVEL_MSB     8
`define GBU_BUF_WORDS     10
`define GBU_BUF_BITS      160
`define GBU_OVERSAMPLE    16
`define GBU_TAIL_QBITS    32
`define GBU_SAMP_PER_QBIT 4
`define GBU_TAIL_SAMPLES  (`GBU_TAIL_QBITS * `GBU_SAMP_PER_QBIT)
`define GBU_CLK_PERIOD_NS 8
`define GBU_CLK_KHZ       125000
`define GBU_SAMPLE_KHZ    4330
`define GBU_SAMPLE_DIV    ((`GBU_CLK_KHZ + `GBU_SAMPLE_KHZ - 1) / `GBU_SAMPLE_KHZ)
`define GBU_SETTLE_NS     10000
`define GBU_SETTLE_CYC    ((`GBU_SETTLE_NS + `GBU_CLK_PERIOD_NS - 1) / `GBU_CLK_PERIOD_NS)
`define GBU_CAL_STEP_NS   1000
`define GBU_CAL_STEP_CYC  ((`GBU_CAL_STEP_NS + `GBU_CLK_PERIOD_NS - 1) / `GBU_CLK_PERIOD_NS)
`define GBU_OFS_RST       6'h20
`define GBU_REG_CTRL      4'h0
`define GBU_REG_DATA      4'h4
`define GBU_REG_WIN       4'h8
`define GBU_REG_STAT      4'hC
`define GBU_WIN_PWR       0
`define GBU_WIN_CAL       1
`define GBU_WIN_MOD       2
`define GBU_PKT_GAP       2
`endif

// file: gbu_pkg.sv
// types shared by both ends of the burst uplink link
package gbu_pkg;
	typedef enum logic [2:0] {
		GBU_M_IDLE = 3'b001,
		GBU_M_RUN  = 3'b010,
		GBU_M_TAIL = 3'b100
	} gbu_mod_state_t;
	typedef enum logic [2:0] {
		GBU_S_IDLE = 3'b001,
		GBU_S_SEND = 3'b010,
		GBU_S_GAP  = 3'b100
	} gbu_ser_state_t;
	typedef struct packed {
		logic        is_ctrl;
		logic [15:0] word;
	} gbu_pkt_t;
endpackage

// file: gbu_link_if.sv
// link between the uplink controller and the uplink device
`timescale 1ns/100ps
interface gbu_link_if;
	logic pkt_sync;
	logic pkt_data;
	logic pkt_is_ctrl;
	logic power_win;
	logic cal_win;
	logic mod_win;
	logic load_ready;
	logic powered;
	logic modulating;
	modport dev (
		input  pkt_sync, pkt_data, pkt_is_ctrl, power_win, cal_win, mod_win,
		output load_ready, powered, modulating
	);
	modport ctl (
		output pkt_sync, pkt_data, pkt_is_ctrl, power_win, cal_win, mod_win,
		input  load_ready, powered, modulating
	);
endinterface

// file: gbu_uplink_ctl.sv
// uplink controller: avalon registers, packet buffer, serializer, windows
`timescale 1ns/100ps
`include "gbu_params.svh"
module gbu_uplink_ctl
	import gbu_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	gbu_link_if.ctl          lnk
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
		$error("gbu_uplink_ctl: DEPTH must be a power of two, at least 2");
	end

	gbu_pkt_t       fifo_q [0:DEPTH-1];
	logic [PW-1:0]  wr_ptr_q;
	logic [PW-1:0]  rd_ptr_q;
	logic [CW-1:0]  count_q;
	logic           in_valid;
	logic           in_ready;
	logic           out_valid;
	logic           out_ready;
	gbu_pkt_t       head;
	logic           wait_q;
	logic [31:0]    rdata_q;
	logic           req;
	logic           is_push;
	logic           done;
	logic [15:0]    ctrl_shadow_q;
	logic [2:0]     win_q;
	gbu_ser_state_t ser_q;
	logic [15:0]    sh_q;
	logic [3:0]     bcnt_q;
	logic           sync_q;
	logic           data_q;
	logic           is_ctrl_q;

	assign req     = i_avs_read || i_avs_write;
	assign is_push = i_avs_write && (i_avs_address == `GBU_REG_CTRL
		|| i_avs_address == `GBU_REG_DATA);
	assign done    = req && !wait_q;

	// waitrequest drops for one cycle once the access can complete
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end else if (done) begin
			wait_q <= 1'b1;
		end else if (req && (!is_push || in_ready)) begin
			wait_q <= 1'b0;
			case (i_avs_address)
				`GBU_REG_CTRL: rdata_q <= {16'h0000, ctrl_shadow_q};
				`GBU_REG_WIN:  rdata_q <= {29'h00000000, win_q};
				`GBU_REG_STAT: rdata_q <= {26'h0000000, count_q == CW'(DEPTH),
					count_q == '0, ser_q != GBU_S_IDLE, lnk.modulating,
					lnk.powered, lnk.load_ready};
				default:       rdata_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			ctrl_shadow_q <= `GBU_CTRL_RST;
			win_q         <= 3'h0;
		end else if (done && i_avs_write) begin
			if (i_avs_address == `GBU_REG_CTRL)
				ctrl_shadow_q <= i_avs_writedata[15:0];
			if (i_avs_address == `GBU_REG_WIN)
				win_q <= i_avs_writedata[2:0];
		end
	end

	assign in_valid  = done && is_push;
	assign in_ready  = (count_q != CW'(DEPTH));
	assign out_valid = (count_q != '0);
	assign head      = fifo_q[rd_ptr_q];
	assign out_ready = (ser_q == GBU_S_IDLE)
		&& (head.is_ctrl || lnk.load_ready);

	always_ff @(posedge i_core_clk) begin
		if (in_valid && in_ready)
			fifo_q[wr_ptr_q] <= '{is_ctrl: i_avs_address == `GBU_REG_CTRL,
				word: i_avs_writedata[15:0]};
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (in_valid && in_ready)
				wr_ptr_q <= wr_ptr_q + PW'(1);
			if (out_valid && out_ready)
				rd_ptr_q <= rd_ptr_q + PW'(1);
			if ((in_valid && in_ready) && !(out_valid && out_ready))
				count_q <= count_q + CW'(1);
			else if (!(in_valid && in_ready) && (out_valid && out_ready))
				count_q <= count_q - CW'(1);
		end
	end

	// sixteen bits msb first, sync with the first, then an idle gap
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn) begin
			ser_q     <= GBU_S_IDLE;
			sh_q      <= 16'h0000;
			bcnt_q    <= 4'h0;
			sync_q    <= 1'b0;
			data_q    <= 1'b0;
			is_ctrl_q <= 1'b0;
		end else begin
			case (ser_q)
				GBU_S_IDLE: begin
					if (out_valid && out_ready) begin
						sync_q    <= 1'b1;
						data_q    <= head.word[15];
						sh_q      <= {head.word[14:0], 1'b0};
						is_ctrl_q <= head.is_ctrl;
						bcnt_q    <= 4'hF;
						ser_q     <= GBU_S_SEND;
					end
				end
				GBU_S_SEND: begin
					sync_q <= 1'b0;
					data_q <= sh_q[15];
					sh_q   <= {sh_q[14:0], 1'b0};
					bcnt_q <= bcnt_q - 4'h1;
					if (bcnt_q == 4'h1) begin
						bcnt_q <= 4'(`GBU_PKT_GAP);
						ser_q  <= GBU_S_GAP;
					end
				end
				GBU_S_GAP: begin
					data_q <= 1'b0;
					bcnt_q <= bcnt_q - 4'h1;
					if (bcnt_q == 4'h1)
						ser_q <= GBU_S_IDLE;
				end
				default: ser_q <= GBU_S_IDLE;
			endcase
		end
	end

	assign o_avs_readdata    = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign lnk.pkt_sync      = sync_q;
	assign lnk.pkt_data      = data_q;
	assign lnk.pkt_is_ctrl   = is_ctrl_q;
	assign lnk.power_win     = win_q[`GBU_WIN_PWR];
	assign lnk.cal_win       = win_q[`GBU_WIN_CAL];
	assign lnk.mod_win       = win_q[`GBU_WIN_MOD];
endmodule // gbu_uplink_ctl

// file: gbu_link_props.sv
// concurrent checks on the link between uplink controller and device
`timescale 1ns/100ps
module gbu_link_props #(
	parameter int SAMPLE_DIV = 29,
	parameter int SETTLE_CYC = 1250
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic pkt_sync,
	input wire logic pkt_data,
	input wire logic pkt_is_ctrl,
	input wire logic power_win,
	input wire logic cal_win,
	input wire logic mod_win,
	input wire logic load_ready,
	input wire logic powered,
	input wire logic modulating
);
	localparam int TAIL_MIN = 127 * SAMPLE_DIV;
	localparam int TAIL_MAX = 132 * SAMPLE_DIV;
	logic [15:0] pwr_cnt_q;
	logic [15:0] tail_cnt_q;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	// cycles the power window has been high
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn || !power_win)
			pwr_cnt_q <= 16'h0000;
		else if (pwr_cnt_q != 16'hFFFF)
			pwr_cnt_q <= pwr_cnt_q + 16'h0001;
	end
	// cycles of modulation since the enable window closed
	always_ff @(posedge i_core_clk) begin
		if (!i_resetn || mod_win)
			tail_cnt_q <= 16'h0000;
		else if (modulating && tail_cnt_q != 16'hFFFF)
			tail_cnt_q <= tail_cnt_q + 16'h0001;
	end
	AST_SYNC_SPACING: assert property (pkt_sync |=> !pkt_sync [*8] ##1
		!pkt_sync [*8] ##1 !pkt_sync) else $error("packets too close");
	AST_GAP_IDLE: assert property (pkt_sync |-> ##16 !pkt_data ##1
		!pkt_data) else $error("data line not idle in gap");
	AST_DATA_HELD: assert property (pkt_sync && !pkt_is_ctrl |->
		$past(load_ready)) else $error("data sent to full buffer");
	AST_PWR_SETTLE: assert property (powered |->
		pwr_cnt_q >= SETTLE_CYC) else $error("powered before settling");
	AST_PWR_ON: assert property (pwr_cnt_q == SETTLE_CYC + 3 |->
		powered) else $error("power on late");
	AST_PWR_OFF: assert property (!power_win ##1 !power_win |->
		!powered) else $error("power stays on");
	AST_MOD_START: assert property ($rose(modulating) |->
		mod_win && powered) else $error("modulation start unprompted");
	AST_MOD_TAIL: assert property ($fell(modulating) |-> !mod_win &&
		tail_cnt_q >= TAIL_MIN) else $error("modulation tail short");
	AST_MOD_END: assert property (modulating && !mod_win |->
		tail_cnt_q < TAIL_MAX) else $error("modulation tail long");
	AST_RST_IDLE: assert property ($rose(i_resetn) |-> !pkt_sync &&
		!power_win && !cal_win && !mod_win && !modulating)
		else $error("link not idle after reset");
	cover property (pkt_sync && pkt_is_ctrl);
	cover property (pkt_sync && !pkt_is_ctrl);
	cover property ($rose(powered));
	cover property ($fell(modulating));
endmodule // gbu_link_props

// file: testbench.sv
// self-checking bench joining uplink controller and device
`timescale 1ns/100ps
`include "gbu_params.svh"
module testbench;
	localparam int SDIV = 4;
	localparam int SETTLE = 8;
	logic        i_core_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic [3:0]  av_addr = 4'h0;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [31:0] av_wdata = 32'h0;
	logic [31:0] av_rdata;
	logic        av_wait;
	logic        cmp_i = 1'b0;
	logic        cmp_q = 1'b0;
	logic [9:0]  dac_i;
	logic [9:0]  dac_q;
	logic [5:0]  sub_i;
	logic [5:0]  sub_q;
	logic        pwr;
	logic [2:0]  lvl;
	logic [2:0]  cm;
	logic [31:0] rd;
	logic        moved;
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          n;
	gbu_link_if link();
	gbu_uplink_ctl gbu_uplink_ctl_i (.i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_avs_address(av_addr), .i_avs_read(av_rd),
		.i_avs_write(av_wr), .i_avs_writedata(av_wdata),
		.o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .lnk(link));
	gbu_uplink_dev #(.SAMPLE_DIV(SDIV), .SETTLE_CYC(SETTLE), .CAL_STEP_CYC(2))
		gbu_uplink_dev_i (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.lnk(link), .i_cmp_i_high(cmp_i), .i_cmp_q_high(cmp_q),
		.o_dac_i(dac_i), .o_dac_q(dac_q), .o_sub_dac_i(sub_i),
		.o_sub_dac_q(sub_q), .o_uplink_power(pwr), .o_out_level(lvl),
		.o_common_mode(cm));
	gbu_link_props #(.SAMPLE_DIV(SDIV), .SETTLE_CYC(SETTLE)) gbu_link_props_i (
		.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.pkt_sync(link.pkt_sync), .pkt_data(link.pkt_data),
		.pkt_is_ctrl(link.pkt_is_ctrl), .power_win(link.power_win),
		.cal_win(link.cal_win), .mod_win(link.mod_win),
		.load_ready(link.load_ready), .powered(link.powered),
		.modulating(link.modulating));
	always #4 i_core_clk = ~i_core_clk;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one avalon access; holds until waitrequest is sampled low
	task automatic av_xfer(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge i_core_clk);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= wr;
		av_rd <= !wr;
		@(posedge i_core_clk);
		while (av_wait !== 1'b0) @(posedge i_core_clk);
		rd = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	// polls status until the masked bits match, then compares
	task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
		repeat (400) begin
			av_xfer(1'b0, `GBU_REG_STAT, 32'h0);
			if ((rd & mask) === val) break;
		end
		check("status", rd & mask, val);
	endtask
	task automatic set_ctrl(input logic [15:0] v);
		av_xfer(1'b1, `GBU_REG_CTRL, {16'h0, v});
		wait_stat(32'h18, 32'h10);
		check("level", lvl, v[8:6]);
		check("common mode", cm, v[2:0]);
		av_xfer(1'b0, `GBU_REG_CTRL, 32'h0);
		check("ctrl readback", rd, v);
	endtask
	task automatic load_words(input int cnt);
		for (int k = 0; k < cnt; k++)
			av_xfer(1'b1, `GBU_REG_DATA, 32'hA5C3 ^ (k * 32'h1357));
	endtask
	initial begin
		repeat (8) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		check("dac i", dac_i, 32'h1FF);
		check("dac q", dac_q, 32'h0);
		check("sub i", sub_i, `GBU_OFS_RST);
		check("sub q", sub_q, `GBU_OFS_RST);
		check("power", pwr, 32'h0);
		av_xfer(1'b1, 4'h3, 32'h1FF);
		av_xfer(1'b0, 4'h2, 32'h0);
		check("unmapped", rd, 32'h0);
		av_xfer(1'b0, `GBU_REG_CTRL, 32'h0);
		check("ctrl reset", rd, `GBU_CTRL_RST);
		wait_stat(32'h3F, 32'h11);
		$display("test reset done");
		av_xfer(1'b1, `GBU_REG_WIN, 32'h4);
		repeat (20) @(posedge i_core_clk);
		wait_stat(32'h6, 32'h0);
		av_xfer(1'b1, `GBU_REG_WIN, 32'h0);
		set_ctrl(16'h0142);
		load_words(10);
		wait_stat(32'h19, 32'h10);
		set_ctrl(16'h01E5);
		wait_stat(32'h1, 32'h1);
		load_words(11);
		wait_stat(32'h11, 32'h0);
		$display("test load done");
		cmp_i <= 1'b1;
		av_xfer(1'b1, `GBU_REG_WIN, 32'h1);
		n = 0;
		while (pwr !== 1'b1 && n < 300) begin
			@(posedge i_core_clk);
			n++;
		end
		check("settle", n >= SETTLE && n < 300, 32'h1);
		av_xfer(1'b1, `GBU_REG_WIN, 32'h3);
		repeat (3) @(posedge i_core_clk);
		check("cal dac i", dac_i, 32'h0);
		check("cal dac q", dac_q, 32'h0);
		av_xfer(1'b0, `GBU_REG_WIN, 32'h0);
		check("window readback", rd, 32'h3);
		repeat (150) @(posedge i_core_clk);
		check("sweep i", sub_i, 32'h0);
		check("sweep q", sub_q, 32'h3F);
		av_xfer(1'b1, `GBU_REG_WIN, 32'h1);
		$display("test calibration done");
		av_xfer(1'b1, `GBU_REG_WIN, 32'h5);
		wait_stat(32'h4, 32'h4);
		moved = 1'b0;
		repeat (200) begin
			@(posedge i_core_clk);
			if (dac_i !== 10'h1FF || dac_q !== 10'h0)
				moved = 1'b1;
		end
		check("modulated", moved, 32'h1);
		av_xfer(1'b1, `GBU_REG_WIN, 32'h1);
		n = 0;
		while (link.modulating !== 1'b0 && n < 2000) begin
			@(posedge i_core_clk);
			n++;
		end
		check("tail", n >= 127 * SDIV && n <= 131 * SDIV, 32'h1);
		repeat (2 * SDIV) @(posedge i_core_clk);
		check("end dac i", dac_i, 32'h1FF);
		check("end dac q", dac_q, 32'h0);
		wait_stat(32'h11, 32'h11);
		av_xfer(1'b1, `GBU_REG_WIN, 32'h0);
		repeat (3) @(posedge i_core_clk);
		check("power off", pwr, 32'h0);
		$display("test modulation done");
		stop_test();
	end
endmodule // testbench
